// file: common/blp_pkg.sv
// Shared constants and types for the parallel bootloader sequencer
package blp_pkg;
	// Clock and timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int PROG_PULSE_NS = 2_000_000;
	localparam int PROG_PULSE_CYC = (PROG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FLASH_HALF_NS = 100_000_000;
	localparam int FLASH_HALF_CYC = FLASH_HALF_NS / CLK_PERIOD_NS;

	// Address map of the transfer
	localparam logic [15:0] BOOT_ENTRY = 16'h7F00;
	localparam logic [15:0] EP_CHAR_LO = 16'h0400;
	localparam logic [15:0] EP_CHAR_HI = 16'h0AFF;
	localparam logic [15:0] EP_PROG_LO = 16'h2000;
	localparam logic [15:0] EP_PROG_HI = 16'h7EFF;
	localparam logic [15:0] EP_VEC_LO = 16'h7FF0;
	localparam logic [15:0] EP_VEC_HI = 16'h7FFF;
	localparam logic [15:0] RAM_LO = 16'h0100;
	localparam logic [15:0] RAM_HI = 16'h01FF;
	localparam logic [15:0] RAM_EXEC = 16'h0100;
	localparam logic [7:0] LOW_WRAP = 8'hFF;

	// Mode codes, first switch in the high bit
	localparam logic [1:0] MODE_PROG_VER = 2'h0;
	localparam logic [1:0] MODE_VER = 2'h1;
	localparam logic [1:0] MODE_RAM = 2'h2;
	localparam logic [1:0] MODE_EXEC = 2'h3;

	// Pass numbering
	localparam logic [1:0] PASS_FIRST = 2'h0;
	localparam logic [1:0] PASS_VERIFY = 2'h2;

	// LED field
	localparam int LED_PASS_BIT = 7;

	// Register byte offsets
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_ADDR = 4'h8;
	localparam logic [31:0] REG_ZERO = 32'h0000_0000;
	localparam int CTRL_HOLD_BIT = 0;
	localparam int CTRL_RESTART_BIT = 1;
	localparam int STAT_RUN_BIT = 0;
	localparam int STAT_PASS_BIT = 1;
	localparam int STAT_FAIL_BIT = 2;
	localparam int STAT_STOP_BIT = 3;
	localparam int STAT_EXEC_BIT = 4;
	localparam int STAT_MODE_LSB = 8;

	typedef enum logic [3:0] {
		ST_BOOT, ST_INIT, ST_LATCH, ST_SELECT, ST_HS_HI, ST_HS_LO, ST_XFER,
		ST_PROG, ST_NEXT, ST_PASS, ST_FAIL, ST_STOP, ST_EXEC
	} blp_state_e;
endpackage

// file: rtl/blp_tick.sv
// Divider producing a one-cycle enable pulse every PERIOD cycles
`timescale 1ns/10ps
module blp_tick import blp_pkg::*; #(
	parameter int PERIOD = FLASH_HALF_CYC
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic en,
	output logic tick
);
	typedef struct packed {
		logic [31:0] cnt;
		logic tick;
	} blp_tick_s;

	blp_tick_s r_reg;
	blp_tick_s r_next;

	always_comb begin
		r_next = r_reg;
		r_next.tick = 1'b0;
		if (!en) begin
			r_next.cnt = '0;
		end else if (r_reg.cnt == 32'(PERIOD - 1)) begin
			r_next.cnt = '0;
			r_next.tick = 1'b1;
		end else begin
			r_next.cnt = r_reg.cnt + 32'h0000_0001;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign tick = r_reg.tick;
endmodule

// file: rtl/blp_timer.sv
// One-shot timer: busy for CYCLES cycles after start, then a done pulse
`timescale 1ns/10ps
module blp_timer import blp_pkg::*; #(
	parameter int CYCLES = PROG_PULSE_CYC
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic start,
	output logic busy,
	output logic done
);
	typedef struct packed {
		logic [31:0] cnt;
		logic busy;
		logic done;
	} blp_tmr_s;

	blp_tmr_s r_reg;
	blp_tmr_s r_next;

	always_comb begin
		r_next = r_reg;
		r_next.done = 1'b0;
		if (start) begin
			r_next.cnt = 32'(CYCLES - 1);
			r_next.busy = 1'b1;
		end else if (r_reg.busy) begin
			if (r_reg.cnt == '0) begin
				r_next.busy = 1'b0;
				r_next.done = 1'b1;
			end else begin
				r_next.cnt = r_reg.cnt - 32'h0000_0001;
			end
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign busy = r_reg.busy;
	assign done = r_reg.done;
endmodule

// file: rtl/blp_loader.sv
// Bootloader sequencer: copies a parallel source into on-chip EPROM or RAM
// Overview of operation
// [R1] Both mode switches high at start: run RAM
// [R2] Otherwise map character store, set up ports
// [R3] Address starts at first character location
// [R4] First switch picks RAM loader or EPROM modes
// [R5] Codes: 00 program, 01 verify, 10 RAM, 11 run
// [R6] Without loopback, wait with ready high
// [R7] Source pulses strobe high then low
// [R8] RAM window copied, verified, pass LED, stop
// [R9] Verify failure halts at failing address
// [R10] Second switch in RAM mode shows inverted RAM
// [R11] Second switch at RAM pass: run RAM
// [R12] EPROM walk visits only three areas
// [R13] Two programming passes, 2 ms per byte
// [R14] Then one verify pass, pass LED on match
// [R15] LEDs: high address byte or low seven bits
// [R16] Activity LED flashes while loader runs
// [R17] RAM mode single-steps one address per strobe
// [R18] Low address on port, high byte latched
// [R19] Sequencer enters at its boot entry only
// [R20] Low wrap bumps high byte and latches it
// [R21] Data sampled only after completed handshake
`timescale 1ns/10ps
module blp_loader import blp_pkg::*; #(
	parameter int PROG_CYCLES = PROG_PULSE_CYC,
	parameter int FLASH_CYCLES = FLASH_HALF_CYC
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic first_mode_switch,
	input wire logic second_mode_switch,
	input wire logic [7:0] src_data,
	input wire logic hs_strobe,
	output logic hs_ready,
	output logic [7:0] addr_lo,
	output logic [7:0] addr_hi,
	output logic addr_hi_latch,
	output logic [7:0] led_port,
	output logic activity_led,
	output logic display_character_store_en,
	output logic [15:0] nvm_addr,
	output logic [7:0] nvm_wdata,
	output logic nvm_prog_en,
	input wire logic [7:0] nvm_rdata,
	output logic stop_mode,
	output logic exec_ram,
	output logic [15:0] exec_addr
);
	typedef struct packed {
		blp_state_e st;
		logic [1:0] mode;
		logic [1:0] pass_n;
		logic selected;
		logic [15:0] addr;
		logic [7:0] data;
		logic [7:0] leds;
		logic latch_p;
		logic char_map;
		logic act;
		logic hold;
		logic ack;
		logic [31:0] rdata;
	} blp_loader_s;

	blp_loader_s r_reg;
	blp_loader_s r_next;
	logic [7:0] ram_mem [256];
	logic ram_we;
	logic tmr_start;
	logic tmr_done;
	logic flash_tick;
	logic running;
	logic is_ram;
	logic [7:0] ram_rd;
	logic [15:0] walk_next;
	logic walk_last;
	logic [15:0] walk_first;
	logic [1:0] mode_now;
	logic restart;
	logic req;

	assign mode_now = {first_mode_switch, second_mode_switch};
	assign is_ram = (r_reg.mode == MODE_RAM);
	assign ram_rd = ram_mem[r_reg.addr[7:0]];
	assign running = (r_reg.st != ST_STOP) && (r_reg.st != ST_EXEC) &&
		(r_reg.st != ST_FAIL) && (r_reg.st != ST_PASS);
	assign req = avs_read || avs_write;
	assign restart = r_reg.ack && avs_write && (avs_address == REG_CTRL) &&
		avs_writedata[CTRL_RESTART_BIT];

	// Skips the gaps between the character, program and vector areas
	always_comb begin
		walk_next = r_reg.addr + 16'h0001;
		walk_last = 1'b0;
		walk_first = EP_CHAR_LO;
		if (is_ram) begin
			walk_first = RAM_LO;
			walk_last = (r_reg.addr == RAM_HI);
		end else if (r_reg.addr == EP_CHAR_HI) begin
			walk_next = EP_PROG_LO; // [R12]
		end else if (r_reg.addr == EP_PROG_HI) begin
			walk_next = EP_VEC_LO; // [R12]
		end else if (r_reg.addr == EP_VEC_HI) begin
			walk_last = 1'b1; // [R12]
		end
	end

	always_comb begin
		r_next = r_reg;
		r_next.latch_p = 1'b0;
		ram_we = 1'b0;
		tmr_start = 1'b0;
		if (flash_tick) begin
			r_next.act = ~r_reg.act; // [R16]
		end
		if (!running) begin
			r_next.act = 1'b0;
		end
		unique case (r_reg.st)
			ST_BOOT: begin
				r_next.mode = mode_now;
				if (mode_now == MODE_EXEC) begin
					r_next.addr = RAM_EXEC; // [R1] [R5]
					r_next.st = ST_EXEC;
				end else begin
					r_next.st = ST_INIT;
				end
			end
			ST_INIT: begin
				r_next.char_map = 1'b1; // [R2]
				r_next.leds = '0;
				r_next.addr = EP_CHAR_LO; // [R3]
				r_next.pass_n = PASS_FIRST;
				r_next.selected = 1'b0;
				r_next.st = ST_LATCH;
			end
			ST_LATCH: begin
				r_next.latch_p = 1'b1; // [R18] [R20]
				r_next.st = r_reg.selected ? ST_HS_HI : ST_SELECT;
			end
			ST_SELECT: begin
				r_next.selected = 1'b1;
				if (r_reg.mode[1]) begin
					r_next.addr = RAM_LO; // [R4] [R17]
					r_next.st = ST_LATCH;
				end else begin
					r_next.pass_n = r_reg.mode[0] ? PASS_VERIFY : PASS_FIRST; // [R4] [R5]
					r_next.st = ST_HS_HI;
				end
			end
			ST_HS_HI: begin
				// Ready drops once strobe is seen so a loopback wire returns low
				if (hs_strobe && !r_reg.hold) begin
					r_next.st = ST_HS_LO; // [R6] [R7]
				end
			end
			ST_HS_LO: begin
				if (!hs_strobe) begin
					r_next.st = ST_XFER; // [R7] [R21]
				end
			end
			ST_XFER: begin
				r_next.data = src_data; // [R21]
				r_next.st = ST_NEXT;
				if (is_ram) begin
					r_next.leds = {r_reg.leds[LED_PASS_BIT], r_reg.addr[6:0]}; // [R15]
					if (second_mode_switch) begin
						r_next.leds = ~ram_rd; // [R10]
					end
				end else begin
					r_next.leds = r_reg.addr[15:8]; // [R15]
				end
				if (r_reg.pass_n == PASS_VERIFY) begin
					if ((is_ram ? ram_rd : nvm_rdata) != src_data) begin
						r_next.st = ST_FAIL; // [R9]
					end
				end else if (is_ram) begin
					ram_we = !second_mode_switch; // [R8] [R10]
				end else begin
					tmr_start = 1'b1; // [R13]
					r_next.st = ST_PROG;
				end
			end
			ST_PROG: begin
				if (tmr_done) begin
					r_next.st = ST_NEXT;
				end
			end
			ST_NEXT: begin
				if (walk_last) begin
					if (r_reg.pass_n == PASS_VERIFY) begin
						r_next.st = ST_PASS; // [R14]
					end else begin
						// RAM has one load pass, EPROM two programming passes
						r_next.pass_n = is_ram ? PASS_VERIFY : r_reg.pass_n + 2'h1; // [R13]
						r_next.addr = walk_first;
						r_next.st = ST_LATCH;
					end
				end else begin
					r_next.addr = walk_next; // [R17] [R20]
					r_next.st = (r_reg.addr[7:0] == LOW_WRAP) ? ST_LATCH : ST_HS_HI;
				end
			end
			ST_PASS: begin
				r_next.leds[LED_PASS_BIT] = 1'b1; // [R8] [R14]
				if (is_ram && second_mode_switch) begin
					r_next.addr = RAM_EXEC; // [R11]
					r_next.st = ST_EXEC;
				end else begin
					r_next.st = ST_STOP; // [R8]
				end
			end
			ST_FAIL: r_next.st = ST_FAIL; // [R9]
			ST_STOP: r_next.st = ST_STOP;
			ST_EXEC: r_next.st = ST_EXEC;
			default: r_next.st = ST_BOOT;
		endcase
		if (restart) begin
			r_next.st = ST_BOOT;
		end

		// Avalon slave: one wait cycle, read data captured in the first
		r_next.ack = req && !r_reg.ack;
		if (req && !r_reg.ack && avs_read) begin
			unique case (avs_address)
				REG_CTRL: r_next.rdata = {31'h0000_0000, r_reg.hold};
				REG_STATUS: begin
					r_next.rdata = REG_ZERO;
					r_next.rdata[STAT_RUN_BIT] = running;
					r_next.rdata[STAT_PASS_BIT] = r_reg.leds[LED_PASS_BIT];
					r_next.rdata[STAT_FAIL_BIT] = (r_reg.st == ST_FAIL);
					r_next.rdata[STAT_STOP_BIT] = (r_reg.st == ST_STOP);
					r_next.rdata[STAT_EXEC_BIT] = (r_reg.st == ST_EXEC);
					r_next.rdata[STAT_MODE_LSB +: 2] = r_reg.mode;
				end
				REG_ADDR: r_next.rdata = {16'h0000, r_reg.addr};
				default: r_next.rdata = REG_ZERO;
			endcase
		end
		if (r_reg.ack && avs_write && avs_address == REG_CTRL) begin
			r_next.hold = avs_writedata[CTRL_HOLD_BIT];
		end
	end

	// Sequencer state only ever resets to its boot entry point
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			r_reg <= '0; // [R19]
			r_reg.st <= ST_BOOT; // [R19]
			r_reg.addr <= BOOT_ENTRY;
		end else begin
			r_reg <= r_next;
		end
	end

	// Program store holds no reset so it maps onto plain RAM
	always_ff @(posedge core_clk) begin
		if (ram_we) begin
			ram_mem[r_reg.addr[7:0]] <= src_data; // [R8]
		end
	end

	blp_timer #(.CYCLES(PROG_CYCLES)) u_prog_timer (
		.core_clk(core_clk),
		.nrst(nrst),
		.start(tmr_start),
		.busy(nvm_prog_en),
		.done(tmr_done)
	);

	blp_tick #(.PERIOD(FLASH_CYCLES)) u_flash (
		.core_clk(core_clk),
		.nrst(nrst),
		.en(running),
		.tick(flash_tick)
	);

	assign avs_waitrequest = req && !r_reg.ack;
	assign avs_readdata = r_reg.rdata;
	assign hs_ready = (r_reg.st == ST_HS_HI) && !r_reg.hold; // [R6]
	assign addr_lo = r_reg.addr[7:0]; // [R18]
	assign addr_hi = r_reg.addr[15:8];
	assign addr_hi_latch = r_reg.latch_p;
	assign led_port = r_reg.leds;
	assign activity_led = r_reg.act;
	assign display_character_store_en = r_reg.char_map;
	assign nvm_addr = r_reg.addr;
	assign nvm_wdata = r_reg.data;
	assign stop_mode = (r_reg.st == ST_STOP);
	assign exec_ram = (r_reg.st == ST_EXEC);
	assign exec_addr = RAM_EXEC;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	property p_exec_direct;
		(r_reg.st == ST_BOOT && mode_now == MODE_EXEC && !restart) |=> exec_ram;
	endproperty
	a_exec_direct: assert property (p_exec_direct) else $error("no direct run"); // [R1]

	property p_init_map;
		(r_reg.st == ST_INIT && !restart) |=> display_character_store_en && addr_lo == 8'h00
			&& addr_hi == EP_CHAR_LO[15:8] ##1 addr_hi_latch;
	endproperty
	a_init_map: assert property (p_init_map) else $error("bad init"); // [R2] [R3]

	property p_ram_select;
		(r_reg.st == ST_SELECT && r_reg.mode == MODE_RAM && !restart) |=>
			r_reg.addr == RAM_LO;
	endproperty
	a_ram_select: assert property (p_ram_select) else $error("bad RAM start"); // [R4]

	// A hold written in the waiting cycle may drop ready, but the wait itself must go on
	property p_ready_wait;
		(r_reg.st == ST_HS_HI && !r_reg.hold && !hs_strobe && !restart) |=>
			r_reg.st == ST_HS_HI && hs_ready == !r_reg.hold;
	endproperty
	a_ready_wait: assert property (p_ready_wait) else $error("ready not held"); // [R6]

	property p_fail_hold;
		(r_reg.st == ST_FAIL && !restart) |=> $stable(r_reg.addr) [*3];
	endproperty
	a_fail_hold: assert property (p_fail_hold) else $error("fail address moved"); // [R9]

	property p_prog_pulse;
		$rose(nvm_prog_en) |-> $stable(nvm_addr) [*8] ##0 nvm_prog_en;
	endproperty
	a_prog_pulse: assert property (p_prog_pulse) else $error("short program pulse"); // [R13]

	property p_gap_skip;
		(r_reg.st == ST_NEXT && !is_ram && r_reg.addr == EP_CHAR_HI && !restart) |=>
			r_reg.addr == EP_PROG_LO ##1 addr_hi_latch;
	endproperty
	a_gap_skip: assert property (p_gap_skip) else $error("gap not skipped"); // [R12] [R20]

	property p_led_high;
		(r_reg.st == ST_XFER && !is_ram && !restart) |=> led_port == $past(addr_hi);
	endproperty
	a_led_high: assert property (p_led_high) else $error("LEDs not high byte"); // [R15]

	property p_ram_view;
		(r_reg.st == ST_XFER && is_ram && second_mode_switch && !restart) |=>
			led_port == ~$past(ram_rd);
	endproperty
	a_ram_view: assert property (p_ram_view) else $error("RAM view wrong"); // [R10]

	c_pass_stop: cover property (r_reg.st == ST_PASS ##1 stop_mode);
	c_fail: cover property ($rose(r_reg.st == ST_FAIL));
	c_ram_exec: cover property (r_reg.st == ST_PASS && is_ram ##1 exec_ram);
	c_wrap: cover property (r_reg.st == ST_NEXT && addr_lo == LOW_WRAP ##2 addr_hi_latch);
endmodule

// file: dv/blp_src_model.sv
// Stand-in for the source EPROM with ready/strobe handshake and high address latch
`timescale 1ns/10ps
module blp_src_model (
	input wire logic core_clk,
	input wire logic hs_ready,
	input wire logic [7:0] addr_lo,
	input wire logic [7:0] addr_hi,
	input wire logic addr_hi_latch,
	input wire logic step_mode,
	input wire logic step,
	output logic hs_strobe,
	output logic [7:0] src_data,
	output logic [7:0] hi_latched
);
	logic valid;
	function automatic logic [7:0] pat(input logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'hA5;
	endfunction
	initial begin
		hs_strobe = 1'b0;
		valid = 1'b0;
		hi_latched = 8'h00;
	end
	// External latch keeps the high byte between wraps
	always @(posedge core_clk) if (addr_hi_latch) hi_latched <= addr_hi;
	// One strobe pulse per ready; in step mode only when the button is pressed
	always @(posedge core_clk) begin
		if (hs_strobe) begin
			hs_strobe <= 1'b0;
		end else if (hs_ready && (!step_mode || step)) begin
			hs_strobe <= 1'b1;
			valid <= 1'b1;
		end else if (hs_ready) begin
			valid <= 1'b0;
		end
	end
	// Before the first strobe and while step mode waits on the button, the bus shows the inverse so a stale sample cannot pass
	assign src_data = valid ? pat({hi_latched, addr_lo}) : ~pat({hi_latched, addr_lo});
endmodule

// file: dv/testbench.sv
// Self-checking bench for the bootloader sequencer
`timescale 1ns/10ps
module testbench import blp_pkg::*;;
	logic core_clk = 0, nrst = 0, avs_read = 0, avs_write = 0, sw1 = 1, sw2 = 1;
	logic hs_strobe, hs_ready, addr_hi_latch, activity_led, dcs_en, nvm_prog_en;
	logic stop_mode, exec_ram, avs_waitrequest, step_mode = 0, step = 0, act_q = 0;
	logic [3:0] avs_address = 4'h0;
	logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, rd;
	logic [7:0] src_data, addr_lo, addr_hi, led_port, nvm_wdata, nvm_rdata, hi_q;
	logic [15:0] nvm_addr, exec_addr, bad = 16'hFFFF;
	int n_mismatch = 0, n_compared = 0, cyc = 0, n_flash = 0, i;
	always #5 core_clk = ~core_clk;
	assign nvm_rdata = src.pat(nvm_addr) ^ ((nvm_addr == bad) ? 8'hFF : 8'h00);
	blp_loader #(.PROG_CYCLES(20), .FLASH_CYCLES(8)) dut (.core_clk, .nrst, .avs_address,
		.avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
		.first_mode_switch(sw1), .second_mode_switch(sw2), .src_data, .hs_strobe, .hs_ready,
		.addr_lo, .addr_hi, .addr_hi_latch, .led_port, .activity_led,
		.display_character_store_en(dcs_en), .nvm_addr, .nvm_wdata, .nvm_prog_en, .nvm_rdata,
		.stop_mode, .exec_ram, .exec_addr);
	blp_src_model src (.core_clk, .hs_ready, .addr_lo, .addr_hi, .addr_hi_latch, .step_mode,
		.step, .hs_strobe, .src_data, .hi_latched(hi_q));
	task automatic tally_and_finish();
		if (n_mismatch == 0 && n_compared > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	// Switches must be steady before the sequencer resamples them at boot
	task automatic restart(input logic [1:0] m);
		sw1 <= m[1];
		sw2 <= m[0];
		bus(1'b1, REG_CTRL, 32'h0000_0002);
	endtask
	function automatic logic inr(input logic [15:0] a);
		return (a >= RAM_LO && a <= RAM_HI) || (a >= EP_CHAR_LO && a <= EP_CHAR_HI)
			|| (a >= EP_PROG_LO && a <= EP_PROG_HI) || (a >= EP_VEC_LO && a <= EP_VEC_HI);
	endfunction
	always @(posedge core_clk) begin
		cyc++;
		act_q <= activity_led;
		if (activity_led !== act_q) n_flash++;
		if (hs_ready === 1'b1) chk("ready address", 1, inr({hi_q, addr_lo}));
		if (cyc == 40000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (20) @(posedge core_clk);
		chk("addr_hi", 8'h7F, addr_hi);
		chk("addr_lo", 8'h00, addr_lo);
		chk("exec_addr", RAM_EXEC, exec_addr);
		nrst <= 1'b1;
		repeat (10) @(posedge core_clk);
		chk("exec_ram", 1, exec_ram);
		chk("char store", 0, dcs_en);
		bus(1'b1, REG_STATUS, 32'hFFFF_FFFF);
		bus(1'b0, REG_STATUS, REG_ZERO);
		chk("status", {MODE_EXEC, 1'b1}, {rd[9:8], rd[STAT_EXEC_BIT]});
		// Read after a non-zero status so a stuck read register shows up
		bus(1'b0, 4'hC, REG_ZERO);
		chk("unmapped", REG_ZERO, rd);
		restart(MODE_RAM);
		for (i = 0; i < 100 && addr_hi_latch !== 1'b1; i++) @(posedge core_clk);
		chk("first high", 8'h04, addr_hi);
		chk("char store", 1, dcs_en);
		// LEDs follow the byte just moved, so look while waiting on the one after it
		for (i = 0; i < 900 && !(hs_ready === 1'b1 && addr_lo == 8'h34); i++) @(posedge core_clk);
		chk("led addr", 7'h33, led_port[6:0]);
		chk("latched high", 8'h01, hi_q);
		for (i = 0; i < 9000 && stop_mode !== 1'b1; i++) @(posedge core_clk);
		chk("stop", 1, stop_mode);
		chk("pass led", 1, led_port[LED_PASS_BIT]);
		chk("exec_ram", 0, exec_ram);
		chk("flashing", 1, n_flash > 2);
		chk("activity off", 0, activity_led);
		step_mode <= 1'b1;
		restart(MODE_RAM);
		for (i = 0; i < 200 && !(hs_ready === 1'b1 && hi_q == 8'h01); i++) @(posedge core_clk);
		repeat (40) @(posedge core_clk);
		chk("waiting ready", 1, hs_ready);
		chk("step start", 8'h00, addr_lo);
		bus(1'b1, REG_CTRL, 32'h0000_0001);
		bus(1'b0, REG_CTRL, REG_ZERO);
		chk("hold bit", 1, rd[CTRL_HOLD_BIT]);
		chk("held ready", 0, hs_ready);
		bus(1'b1, REG_CTRL, REG_ZERO);
		step <= 1'b1;
		@(posedge core_clk);
		step <= 1'b0;
		repeat (40) @(posedge core_clk);
		chk("one step", 8'h01, addr_lo);
		chk("waiting ready", 1, hs_ready);
		step_mode <= 1'b0;
		for (i = 0; i < 9000 && stop_mode !== 1'b1; i++) @(posedge core_clk);
		chk("pass led", 1, led_port[LED_PASS_BIT]);
		restart(MODE_RAM);
		repeat (4) @(posedge core_clk);
		sw2 <= 1'b1;
		for (i = 0; i < 900 && !(hs_ready === 1'b1 && addr_lo == 8'h11); i++) @(posedge core_clk);
		chk("ram on led", {24'h00_0000, ~src.pat(16'h0110)}, led_port);
		for (i = 0; i < 9000 && exec_ram !== 1'b1; i++) @(posedge core_clk);
		chk("run ram", 1, exec_ram);
		chk("no stop", 0, stop_mode);
		// Failure placed just past the first gap so the skip is walked as well
		bad = 16'h2001;
		restart(MODE_VER);
		for (i = 0; i < 4000 && rd[STAT_FAIL_BIT] !== 1'b1; i++) bus(1'b0, REG_STATUS, REG_ZERO);
		chk("mode field", MODE_VER, rd[9:8]);
		repeat (30) @(posedge core_clk);
		chk("fail addr lo", 8'h01, addr_lo);
		chk("fail addr hi", 8'h20, hi_q);
		chk("pass led", 0, led_port[LED_PASS_BIT]);
		bus(1'b0, REG_ADDR, REG_ZERO);
		chk("addr reg", 16'h2001, rd[15:0]);
		bad = 16'hFFFF;
		restart(MODE_PROG_VER);
		for (i = 0; i < 200 && nvm_prog_en !== 1'b1; i++) @(posedge core_clk);
		for (i = 0; i < 100 && nvm_prog_en === 1'b1; i++) @(posedge core_clk);
		chk("prog pulse", 20, i);
		chk("led high byte", 8'h04, led_port);
		chk("prog data", src.pat(nvm_addr), nvm_wdata);
		tally_and_finish();
	end
endmodule
